// [dv/spp_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
module spp_pin_model (
  input  wire spp_pkg::spp_pins_t pins,
  input  wire logic [7:0]         ext,
  output logic      [7:0]         pin_in
);
  import spp_pkg::*;
  // driven pins show the port's level, released pins the outside driver
  assign pin_in = (pins.oe & pins.out) | (~pins.oe & ext);
endmodule : spp_pin_model
`default_nettype wire

// [dv/strobe_pin_port_with_alt_func_test.sv]
`timescale 1ns/10ps
`default_nettype none
module strobe_pin_port_with_alt_func_test;
  import spp_pkg::*;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0]  paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0]   pstrb = 4'hF, sb;
  logic [31:0]  a_dat = {18'h0, SPP_DATA_IDX, 2'b00}, a_dir = {18'h0, SPP_DIR_IDX, 2'b00};
  logic [31:0]  a_fs = {18'h0, SPP_FSEL_IDX, 2'b00};
  logic         pready, pslverr, er;
  spp_strobes_t strobes = '0;
  spp_pins_t    pins;
  logic [7:0]   ext = 8'hA5, pin_in, md, mr, mf, sv, eo, ee, inm;
  int           errors = 0, cmp_count = 0, seed = 20, n, i;
  always #20 pclk = ~pclk;
  spp_port u_spp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .strobes(strobes), .pin_in(pin_in), .pins(pins));
  spp_pin_model u_spp_pin_model (.pins(pins), .ext(ext), .pin_in(pin_in));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // request stays put until pready is seen at an edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      errors++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, a_fs, 0);
    check(rd, 32'h0);
    apb(1, 32'hFFFFF00C, 32'hFF);
    check({31'h0, er}, 32'h1);
    for (n = 0; n < 40; n++) begin
      md = 8'($random(seed));
      mr = 8'($random(seed));
      mf = 8'($random(seed));
      sb = 4'($random(seed));
      apb(1, a_dat, {24'h0, md});
      apb(1, a_dir, {24'h0, mr});
      apb(1, a_fs, {24'h0, mf});
      strobes <= sb;
      ext <= 8'($random(seed));
      repeat (4) @(posedge pclk);
      mf = mf & 8'h53;
      sv = {1'b0, strobes.address_strobe, 1'b0, strobes.read_strobe, 2'b0,
            strobes.write_strobe_high_lane, strobes.write_strobe_low_lane};
      eo = (mf & sv) | (~mf & md);
      ee = mf | ~mr;
      inm = mr & ~mf;
      check({24'h0, pins.out}, {24'h0, eo});
      check({24'h0, pins.oe}, {24'h0, ee});
      apb(0, a_dat, 0);
      check(rd, {24'h0, (inm & ext) | (~inm & md)});
      apb(0, a_fs, 0);
      check(rd, {24'h0, mf});
      apb(0, a_dir, 0);
      check(rd, {24'h0, mr});
    end
    final_report();
  end
endmodule : strobe_pin_port_with_alt_func_test
`default_nettype wire

// [logic/spp_pkg.sv]
`default_nettype none
package spp_pkg;
  localparam int          SPP_WIDTH        = 8;
  localparam logic [31:0] SPP_DATA_ADDR    = 32'hFFFFF00A;
  localparam logic [31:0] SPP_FSEL_ADDR    = 32'hFFFFF04A;
  localparam logic [31:0] SPP_DIR_ADDR     = 32'hFFFFF02A;
  localparam logic [11:0] SPP_DATA_IDX     = 12'h00A;
  localparam logic [11:0] SPP_FSEL_IDX     = 12'h04A;
  localparam logic [11:0] SPP_DIR_IDX      = 12'h02A;
  localparam logic [7:0]  SPP_FSEL_RESET   = 8'h00;
  localparam logic [7:0]  SPP_FSEL_MASK    = 8'h53;
  localparam logic [7:0]  SPP_DIR_RESET    = 8'hFF;
  localparam logic [7:0]  SPP_DATA_RESET   = 8'h00;
  localparam logic [7:0]  SPP_SMALL_MASK   = 8'hF3;
  localparam logic [7:0]  SPP_LARGE_MASK   = 8'hFF;
  localparam int          SPP_BIT_WR_LOW   = 0;
  localparam int          SPP_BIT_WR_HIGH  = 1;
  localparam int          SPP_BIT_RD       = 4;
  localparam int          SPP_BIT_ADDRESS_STROBE     = 6;

  typedef struct packed {
    logic write_strobe_low_lane;
    logic write_strobe_high_lane;
    logic read_strobe;
    logic address_strobe;
  } spp_strobes_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } spp_pins_t;
endpackage : spp_pkg
`default_nettype wire

// [logic/spp_port.sv]
// How it works
// [R1] width six pins small, eight large
// [R2] small variant lacks bits 2 and 3
// [R3] data register: read pins, write outputs
// [R4] byte or single-bit access via byte/bit masks
// [R5] output data bit drives its pin level
// [R6] direction bit 0 output, 1 input
// [R7] function-select bit picks port or strobe
// [R8] function select resets to zero
// [R9] bit 1 routes high-lane write strobe
// [R10] bits 0,4,6 strobes; others read zero
`timescale 1ns/10ps
`default_nettype none
module spp_port #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  input  wire spp_pkg::spp_strobes_t strobes,
  input  wire logic [7:0]            pin_in,
  output spp_pkg::spp_pins_t         pins
);
  import spp_pkg::*;

  logic [7:0] impl_mask;
  logic [7:0] pin_sync;
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] fsel_q;
  logic [7:0] next_data;
  logic [7:0] next_dir;
  logic [7:0] next_fsel;
  logic [7:0] strobe_vec;
  // one net per vector so that each pin's slice has its own driver
  wire  logic [7:0] read_val;
  wire  logic [7:0] pin_out;
  wire  logic [7:0] pin_oe;
  logic       hit_data;
  logic       hit_dir;
  logic       hit_fsel;
  logic       wr_en;
  logic [7:0] wbyte;

  assign impl_mask = LARGE_VARIANT ? SPP_LARGE_MASK : SPP_SMALL_MASK;  // [R1] [R2]

  spp_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_in),
    .q       (pin_sync)
  );

  // the printed offsets are not word aligned, so each one is kept as a
  // register index and the aligned byte address is four times it;
  // data sits in the low byte of each word
  assign hit_data = (paddr == {18'h00000, SPP_DATA_IDX, 2'b00});
  assign hit_dir  = (paddr == {18'h00000, SPP_DIR_IDX, 2'b00});
  assign hit_fsel = (paddr == {18'h00000, SPP_FSEL_IDX, 2'b00});

  // zero-wait slave: answer in the first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hit_data | hit_dir | hit_fsel);
  assign wr_en   = psel & penable & pwrite & pstrb[0];
  assign wbyte   = pwdata[7:0];

  always_comb begin
    strobe_vec                  = 8'h00;
    strobe_vec[SPP_BIT_WR_LOW]  = strobes.write_strobe_low_lane;   // [R10]
    strobe_vec[SPP_BIT_WR_HIGH] = strobes.write_strobe_high_lane;  // [R9]
    strobe_vec[SPP_BIT_RD]      = strobes.read_strobe;             // [R10]
    strobe_vec[SPP_BIT_ADDRESS_STROBE]    = strobes.address_strobe;          // [R10]
  end

  // single-bit software writes arrive as read-modify-write of the byte,
  // so untouched bits keep their value
  always_comb begin
    next_data = data_q;
    next_dir  = dir_q;
    next_fsel = fsel_q;
    if (wr_en && hit_data) begin
      next_data = wbyte & impl_mask;  // [R3] [R4] [R2]
    end
    if (wr_en && hit_dir) begin
      next_dir = (wbyte & impl_mask) | ~impl_mask;  // [R6] [R2]
    end
    if (wr_en && hit_fsel) begin
      next_fsel = wbyte & SPP_FSEL_MASK;  // [R7] [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= SPP_DATA_RESET;
      dir_q  <= SPP_DIR_RESET;
      fsel_q <= SPP_FSEL_RESET;  // [R8]
    end else begin
      data_q <= next_data;
      dir_q  <= next_dir;
      fsel_q <= next_fsel;
    end
  end

  genvar i;
  generate
    for (i = 0; i < SPP_WIDTH; i++) begin : g_pin
      // alternate mode always drives the pin, whatever the direction bit says
      assign pin_out[i]  = fsel_q[i] ? strobe_vec[i] : data_q[i];  // [R5] [R7] [R9]
      assign pin_oe[i]   = fsel_q[i] | (~dir_q[i] & impl_mask[i]);  // [R6]
      assign read_val[i] = (dir_q[i] && !fsel_q[i]) ?
                           (pin_sync[i] & impl_mask[i]) : data_q[i];  // [R3]
    end
  endgenerate

  assign pins = {pin_out, pin_oe};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      // captured in setup so the access cycle returns stable data
      if (hit_data) begin
        prdata <= {24'h000000, read_val};  // [R3]
      end else if (hit_dir) begin
        prdata <= {24'h000000, dir_q};
      end else if (hit_fsel) begin
        prdata <= {24'h000000, fsel_q};  // [R10]
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  fsel_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> fsel_q == 8'h00)  // [R8]
    else $error("function select not zero after reset");
  fsel_zero_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R10]
    (fsel_q & ~SPP_FSEL_MASK) == 8'h00)
    else $error("reserved select bits set");
  high_lane_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R9]
    fsel_q[1] |-> (pins.out[1] == strobes.write_strobe_high_lane && pins.oe[1]))
    else $error("pin 1 not carrying high-lane strobe");
  port_out_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R5]
    (!fsel_q[0] && !dir_q[0]) |-> (pins.oe[0] && pins.out[0] == data_q[0]))
    else $error("pin 0 output does not follow data");
  dir_input_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R6]
    (dir_q[7] && !fsel_q[7]) |-> !pins.oe[7])
    else $error("input pin driven");
  data_write_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R4]
    (wr_en && hit_data) |=> data_q == ($past(wbyte) & impl_mask))
    else $error("data write not stored");
  small_mask_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R2]
    !LARGE_VARIANT |-> (data_q[3:2] == 2'b00 && pins.oe[3:2] == 2'b00))
    else $error("absent bits active on small variant");
  read_pin_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    (psel && !penable && !pwrite && hit_data && dir_q[5] && !fsel_q[5])
      |=> prdata[5] == $past(pin_sync[5] & impl_mask[5]))
    else $error("input pin level not read");
  strobe_sel_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R7]
    fsel_q[6] |-> pins.out[6] == strobes.address_strobe)
    else $error("address strobe not routed");

  // bus answer checks
  pready_high_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    (psel && penable)
      |-> pready)
    else $error("slave not ready in access phase");

  slverr_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    (psel && penable && !(hit_data || hit_dir || hit_fsel))
      |-> pslverr)
    else $error("unmapped access not flagged");

  slverr_mapped_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    (psel && penable && hit_data)
      |-> !pslverr)
    else $error("mapped access flagged as error");

  // register write and hold checks
  dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R6]
    (wr_en && hit_dir)
      |=> dir_q == (($past(wbyte) & $past(impl_mask)) | ~$past(impl_mask)))
    else $error("direction write not stored");

  fsel_write_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R7]
    (wr_en && hit_fsel)
      |=> fsel_q == ($past(wbyte) & SPP_FSEL_MASK))
    else $error("function select write not stored");

  data_hold_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R4]
    !(wr_en && hit_data)
      |=> $stable(data_q))
    else $error("data changed without a write");

  dir_hold_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R6]
    !(wr_en && hit_dir)
      |=> $stable(dir_q))
    else $error("direction changed without a write");

  fsel_hold_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R8]
    !(wr_en && hit_fsel)
      |=> $stable(fsel_q))
    else $error("function select changed without a write");

  strb_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R4]
    (psel && penable && pwrite && !pstrb[0])
      |=> $stable(data_q))
    else $error("write with lane off took effect");

  // strobe routing checks
  low_lane_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R10]
    fsel_q[0]
      |-> (pins.out[0] == strobes.write_strobe_low_lane && pins.oe[0]))
    else $error("pin 0 not carrying low-lane strobe");

  read_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R10]
    fsel_q[4]
      |-> (pins.out[4] == strobes.read_strobe && pins.oe[4]))
    else $error("pin 4 not carrying read strobe");

  address_strobe_drive_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R10]
    fsel_q[6]
      |-> pins.oe[6])
    else $error("address strobe pin not driven");

  // port mode checks
  port_out1_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R5]
    (!fsel_q[1] && !dir_q[1])
      |-> (pins.oe[1] && pins.out[1] == data_q[1]))
    else $error("pin 1 output does not follow data");

  port_out7_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R5]
    (!fsel_q[7] && !dir_q[7])
      |-> (pins.oe[7] && pins.out[7] == data_q[7]))
    else $error("pin 7 output does not follow data");

  dir_input0_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R6]
    (dir_q[0] && !fsel_q[0])
      |-> !pins.oe[0])
    else $error("input pin 0 driven");

  // read path checks
  read_latch_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    (psel && !penable && !pwrite && hit_data && !dir_q[2] && !fsel_q[2])
      |=> prdata[2] == $past(data_q[2]))
    else $error("output latch not read back");

  read_dir_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R6]
    (psel && !penable && !pwrite && hit_dir)
      |=> prdata[7:0] == $past(dir_q))
    else $error("direction not read back");

  read_fsel_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R10]
    (psel && !penable && !pwrite && hit_fsel)
      |=> prdata[7:0] == $past(fsel_q))
    else $error("function select not read back");

  prdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    psel
      |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  read_hold_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    !(psel && !penable && !pwrite)
      |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  // variant width checks
  width_mask_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R1]
    psel
      |-> (data_q & ~impl_mask) == 8'h00)
    else $error("absent data bits stored");

  dir_absent_a: assert property (@(posedge pclk) disable iff (!presetn)  // [R2]
    psel
      |-> (dir_q | impl_mask) == 8'hFF)
    else $error("absent pins not left as inputs");
endmodule : spp_port
`default_nettype wire

// [logic/spp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module spp_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);
  logic [7:0] meta;
  logic [7:0] next_meta;
  logic [7:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 8'h00;
      q    <= 8'h00;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : spp_sync
`default_nettype wire
